// file: hw/sar_adc_sequencer_accumulator.sv
// Converter sequencer with start selection, clock divider, accumulator and APB registers.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ns
module sar_adc_sequencer_accumulator
(
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [sar_seq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sar_seq_pkg::DATA_W-1:0] pwdata,
  output logic      [sar_seq_pkg::DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          timer0_overflow,
  input  wire logic                          timer2_overflow,
  input  wire logic                          timer2_low_overflow,
  input  wire logic                          timer2_eight_bit,
  input  wire logic                          timer3_overflow,
  input  wire logic                          timer3_low_overflow,
  input  wire logic                          timer3_eight_bit,
  input  wire logic                          external_start_input,
  input  wire logic                          low_power_osc_tick,
  input  wire logic                          dcdc_clock_pin,
  input  wire logic                          dcdc_sync_pin,
  input  wire logic                          standby_sleep,
  input  wire logic                          comparator_bit,
  output logic                               sample_hold_track,
  output logic                               converter_powered,
  output logic                               conversion_clock,
  output logic                               compare_strobe
);
  import sar_seq_pkg::*;

  // All state in one record so a single clocked process owns every flip-flop.
  typedef struct packed
  {
    logic [7:0]          control;
    logic [7:0]          config_r;
    logic [7:0]          accum_cfg;
    logic [7:0]          dcdc_cfg;
    logic [7:0]          result_hi;
    logic [7:0]          result_lo;
    logic [DATA_W-1:0]   rdata;
    logic                ready;
    logic                err;
    logic [1:0]          ext_sync;
    logic [1:0]          dck_sync;
    logic [1:0]          dsy_sync;
    logic                ext_prev;
    logic                dck_prev;
    logic                dsy_prev;
    logic                start_pend;
    logic [5:0]          div_cnt;
    logic                sar_clk;
    seq_state_e          state;
    logic [4:0]          step;
    logic [PWR_W-1:0]    pwr_cnt;
    logic [SAMPLE_W-1:0] sar;
    logic [6:0]          done_cnt;
    logic [ACC_W-1:0]    accum;
    logic                powered;
  } state_s;

  state_s cur_reg;
  state_s cur_next;

  logic       write_access;
  logic       read_access;
  logic       sys_tick;
  logic       osc_tick;
  logic       sar_tick;
  logic       dck_rise;
  logic       sync_pulse;
  logic       start_event;
  logic       busy;
  logic [6:0] repeat_total;
  logic [4:0] conv_clks;
  logic [ACC_W-1:0] sample_ext;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] shifted;
  logic [15:0] final_word;

  assign write_access = psel && penable && pwrite;
  assign read_access  = psel && penable && !pwrite;
  assign busy         = cur_reg.state != ST_IDLE;

  // Repeat field 0 means one sample, then 4, 8, 16, 32, 64.
  always_comb
  begin
    case (cur_reg.accum_cfg[ACC_RPT_LSB +: RPT_W])
      3'h1:    repeat_total = 7'h04;
      3'h2:    repeat_total = 7'h08;
      3'h3:    repeat_total = 7'h10;
      3'h4:    repeat_total = 7'h20;
      3'h5:    repeat_total = 7'h40;
      default: repeat_total = 7'h01;
    endcase
  end

  // Eight-bit mode trims two bit decisions from each conversion.
  assign conv_clks = cur_reg.config_r[CFG_EIGHT_BIT] ? CONV_CLKS_8 : CONV_CLKS_10;

  // The dc-dc clock is synchronised, optionally inverted, and its rising edge clocks the SAR.
  assign dck_rise   = (cur_reg.dck_sync[1] ^ cur_reg.dcdc_cfg[DC_INV_BIT]) &&
                      !(cur_reg.dck_prev ^ cur_reg.dcdc_cfg[DC_INV_BIT]);
  assign sync_pulse = cur_reg.dsy_sync[1] && !cur_reg.dsy_prev;
  assign osc_tick   = low_power_osc_tick;
  assign sys_tick   = 1'b1;

  // Conversion clock enable: dc-dc clock in sync mode, else divided system or oscillator.
  always_comb
  begin
    if (cur_reg.dcdc_cfg[DC_SYNC_BIT])
    begin
      sar_tick = dck_rise;
    end
    else
    begin
      sar_tick = (cur_reg.control[CTL_BURST_BIT] ? osc_tick : sys_tick) &&
                 (cur_reg.div_cnt == {1'b0, cur_reg.config_r[CFG_DIV_LSB +: DIV_W]});
    end
  end

  // Start source selection; timers in 8-bit mode use their low-byte overflow.
  always_comb
  begin
    start_event = 1'b0;
    case (cur_reg.control[CTL_SRC_LSB +: SRC_W])
      SRC_SOFTWARE: start_event = write_access && (paddr == ADDR_CONTROL) &&
                                  pwdata[CTL_BUSY_BIT];
      SRC_TIMER0:   start_event = timer0_overflow;
      SRC_TIMER2:   start_event = timer2_eight_bit ? timer2_low_overflow : timer2_overflow;
      SRC_TIMER3:   start_event = timer3_eight_bit ? timer3_low_overflow : timer3_overflow;
      SRC_EXTERNAL: start_event = cur_reg.ext_sync[1] && !cur_reg.ext_prev;
      default:      start_event = 1'b0;
    endcase
  end

  // Sample widened to accumulator width; the low two bits are zero in eight-bit mode.
  assign sample_ext = {{(ACC_W-SAMPLE_W){1'b0}}, cur_reg.sar};
  assign acc_sum    = cur_reg.accum + sample_ext;

  // Right shift by 1 to 3 when the justify field low bits ask for it.
  assign shifted = acc_sum >> cur_reg.accum_cfg[ACC_SJST_LSB +: 2];

  // Left justification only makes sense for single samples; software keeps 0xx otherwise.
  always_comb
  begin
    if (cur_reg.accum_cfg[ACC_SJST_LSB + 2] && repeat_total == 7'h01)
    begin
      final_word = {cur_reg.sar, 6'h00};
    end
    else
    begin
      final_word = shifted;
    end
  end

  // Next-state logic for registers, synchronisers, divider and sequencer.
  always_comb
  begin
    cur_next = cur_reg;
    cur_next.ready    = 1'b0;
    cur_next.err      = 1'b0;
    cur_next.ext_sync = {cur_reg.ext_sync[0], external_start_input};
    cur_next.dck_sync = {cur_reg.dck_sync[0], dcdc_clock_pin};
    cur_next.dsy_sync = {cur_reg.dsy_sync[0], dcdc_sync_pin};
    cur_next.ext_prev = cur_reg.ext_sync[1];
    cur_next.dck_prev = cur_reg.dck_sync[1];
    cur_next.dsy_prev = cur_reg.dsy_sync[1];

    // Divider counts only on its source tick so the burst clock is the oscillator.
    if (sar_tick)
    begin
      cur_next.div_cnt = 6'h00;
      cur_next.sar_clk = !cur_reg.sar_clk;
    end
    else if (cur_reg.control[CTL_BURST_BIT] ? osc_tick : sys_tick)
    begin
      cur_next.div_cnt = cur_reg.div_cnt + 6'h01;
    end

    // APB access: one wait state, answered in the cycle after penable rises.
    if (psel && penable && !cur_reg.ready)
    begin
      cur_next.ready = 1'b1;
      if (write_access)
      begin
        if (paddr == ADDR_CONTROL)
        begin
          cur_next.control = {pwdata[7:6], cur_reg.control[CTL_DONE_BIT] & pwdata[CTL_DONE_BIT],
                              cur_reg.control[CTL_BUSY_BIT], pwdata[3:0]};
        end
        else if (paddr == ADDR_CONFIG)
          cur_next.config_r = pwdata[7:0];
        else if (paddr == ADDR_ACCUM_CFG)
          cur_next.accum_cfg = pwdata[7:0];
        else if (paddr == ADDR_DCDC_CFG)
          cur_next.dcdc_cfg = pwdata[7:0];
        else if (paddr != ADDR_RESULT_HI && paddr != ADDR_RESULT_LO && paddr != ADDR_STATUS)
          cur_next.err = 1'b1;
      end
      else
      begin
        cur_next.rdata = '0;
        if (paddr == ADDR_CONTROL)
          cur_next.rdata[7:0] = {cur_reg.control[7:5], busy, cur_reg.control[3:0]};
        else if (paddr == ADDR_CONFIG)
          cur_next.rdata[7:0] = cur_reg.config_r;
        else if (paddr == ADDR_ACCUM_CFG)
          cur_next.rdata[7:0] = cur_reg.accum_cfg;
        else if (paddr == ADDR_DCDC_CFG)
          cur_next.rdata[7:0] = cur_reg.dcdc_cfg;
        else if (paddr == ADDR_RESULT_HI)
          cur_next.rdata[7:0] = cur_reg.result_hi;
        else if (paddr == ADDR_RESULT_LO)
          cur_next.rdata[7:0] = cur_reg.result_lo;
        else if (paddr == ADDR_STATUS)
          cur_next.rdata[ST_PWR_LSB +: PWR_W] = cur_reg.pwr_cnt;
        else
          cur_next.err = 1'b1;
        if (paddr == ADDR_STATUS)
        begin
          cur_next.rdata[ST_TRACK_BIT] = sample_hold_track;
          cur_next.rdata[ST_POWER_BIT] = cur_reg.powered;
        end
      end
    end

    // A start waiting for a dc-dc sync pulse is held in a pending flag.
    if (start_event && !busy)
      cur_next.start_pend = 1'b1;

    // Sequencer; starts seen while busy are dropped.
    case (cur_reg.state)
      ST_IDLE:
      begin
        cur_next.powered = cur_reg.control[CTL_POWER_BIT] || !cur_reg.control[CTL_BURST_BIT];
        if ((cur_reg.start_pend || start_event) &&
            (!cur_reg.dcdc_cfg[DC_SYNC_BIT] || sync_pulse))
        begin
          cur_next.start_pend = 1'b0;
          cur_next.step       = 5'h00;
          cur_next.sar        = '0;
          if (cur_reg.done_cnt == 7'h00)
            cur_next.accum = '0;
          if (cur_reg.control[CTL_BURST_BIT] && !cur_reg.control[CTL_POWER_BIT])
          begin
            cur_next.pwr_cnt = cur_reg.config_r[PWR_W-1:0] ^ cur_reg.config_r[PWR_W-1:0];
            cur_next.state   = ST_POWERUP;
            cur_next.powered = 1'b1;
          end
          else if (cur_reg.control[CTL_TRACK_BIT] || cur_reg.control[CTL_BURST_BIT])
            cur_next.state = ST_TRACK;
          else
            cur_next.state = ST_CONVERT;
        end
      end
      ST_POWERUP:
      begin
        if (sar_tick)
        begin
          cur_next.pwr_cnt = cur_reg.pwr_cnt + 4'h1;
          if (cur_reg.pwr_cnt == cur_reg.accum_cfg[7:6] + 4'h0 + cur_reg.config_r[1:0])
            cur_next.state = ST_TRACK;
        end
      end
      ST_TRACK:
      begin
        if (sar_tick)
        begin
          cur_next.step = cur_reg.step + 5'h01;
          if (cur_reg.step + 5'h01 == TRACK_CLKS)
          begin
            cur_next.step  = 5'h00;
            cur_next.state = ST_CONVERT;
          end
        end
      end
      ST_CONVERT:
      begin
        // One bit decision per conversion clock except the last, MSB first.
        if (sar_tick)
        begin
          cur_next.step = cur_reg.step + 5'h01;
          if (cur_reg.step < 5'(SAMPLE_W) && cur_reg.step + 5'h02 <= conv_clks)
            cur_next.sar[SAMPLE_W-1-cur_reg.step[3:0]] = comparator_bit;
          if (cur_reg.step + 5'h01 == conv_clks)
            cur_next.state = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        cur_next.accum    = acc_sum;
        cur_next.done_cnt = cur_reg.done_cnt + 7'h01;
        cur_next.step     = 5'h00;
        cur_next.sar      = '0;
        if (cur_reg.done_cnt + 7'h01 >= repeat_total)
        begin
          cur_next.result_hi = final_word[15:8];
          cur_next.result_lo = final_word[7:0];
          cur_next.control[CTL_DONE_BIT] = 1'b1;
          cur_next.done_cnt = 7'h00;
          cur_next.state    = ST_IDLE;
        end
        else if (cur_reg.control[CTL_BURST_BIT] &&
                 cur_reg.control[CTL_SRC_LSB +: SRC_W] != SRC_EXTERNAL)
          cur_next.state = ST_TRACK;
        else
          cur_next.state = ST_IDLE;
      end
      default:
        cur_next.state = ST_IDLE;
    endcase
  end

  // One register stage for the whole record.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur_reg <= '{state: ST_IDLE, default: '0};
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // Tracking: continuous except converting, or in track phase and while idle with the external start low; off in sleep.
  always_comb
  begin
    if (standby_sleep)
      sample_hold_track = 1'b0;
    else if (cur_reg.control[CTL_TRACK_BIT] || cur_reg.control[CTL_BURST_BIT])
      sample_hold_track = (cur_reg.state == ST_TRACK) ||
                          (cur_reg.control[CTL_SRC_LSB +: SRC_W] == SRC_EXTERNAL &&
                           cur_reg.state == ST_IDLE && !cur_reg.ext_sync[1]);
    else
      sample_hold_track = cur_reg.state != ST_CONVERT && cur_reg.state != ST_FINISH;
  end

  assign converter_powered = cur_reg.powered;
  assign conversion_clock  = cur_reg.sar_clk;
  assign compare_strobe    = (cur_reg.state == ST_CONVERT) && sar_tick;
  assign prdata  = cur_reg.rdata;
  assign pready  = cur_reg.ready;
  assign pslverr = cur_reg.err;
endmodule

// file: hw/sar_seq_pkg.sv
// Package with register map, field layouts and constants of the converter sequencer.
package sar_seq_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  // Register byte addresses on the APB slave.
  localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG     = 8'h04;
  localparam logic [7:0]  ADDR_ACCUM_CFG  = 8'h08;
  localparam logic [7:0]  ADDR_DCDC_CFG   = 8'h0C;
  localparam logic [7:0]  ADDR_RESULT_HI  = 8'h10;
  localparam logic [7:0]  ADDR_RESULT_LO  = 8'h14;
  localparam logic [7:0]  ADDR_STATUS     = 8'h18;
  // Control register fields.
  localparam int          CTL_POWER_BIT   = 7;
  localparam int          CTL_BURST_BIT   = 6;
  localparam int          CTL_DONE_BIT    = 5;
  localparam int          CTL_BUSY_BIT    = 4;
  localparam int          CTL_TRACK_BIT   = 3;
  localparam int          CTL_SRC_LSB     = 0;
  localparam int          SRC_W           = 3;
  // Configuration register fields.
  localparam int          CFG_DIV_LSB     = 3;
  localparam int          DIV_W           = 5;
  localparam int          CFG_EIGHT_BIT   = 2;
  // Accumulator configuration fields.
  localparam int          ACC_SJST_LSB    = 3;
  localparam int          SJST_W          = 3;
  localparam int          ACC_RPT_LSB     = 0;
  localparam int          RPT_W           = 3;
  // Dc-dc configuration fields.
  localparam int          DC_SYNC_BIT     = 0;
  localparam int          DC_INV_BIT      = 1;
  // Status register fields.
  localparam int          ST_TRACK_BIT    = 0;
  localparam int          ST_POWER_BIT    = 1;
  localparam int          PWR_W           = 4;
  localparam int          ST_PWR_LSB      = 8;
  // Start source encodings.
  localparam logic [2:0]  SRC_SOFTWARE    = 3'h0;
  localparam logic [2:0]  SRC_TIMER0      = 3'h1;
  localparam logic [2:0]  SRC_TIMER2      = 3'h2;
  localparam logic [2:0]  SRC_TIMER3      = 3'h3;
  localparam logic [2:0]  SRC_EXTERNAL    = 3'h4;
  // Timing figures in conversion-clock cycles, then sample and accumulator widths in bits.
  localparam logic [4:0]  CONV_CLKS_10    = 5'h0B;
  localparam logic [4:0]  CONV_CLKS_8     = 5'h09;
  localparam logic [4:0]  TRACK_CLKS      = 5'h03;
  localparam int          SAMPLE_W        = 10;
  localparam int          ACC_W           = 16;
  localparam logic [5:0]  LOW_OSC_DIV     = 6'h02;
  localparam logic [1:0]  BUSY_SEEN       = 2'h0;

  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,
    ST_POWERUP = 3'b001,
    ST_TRACK   = 3'b011,
    ST_CONVERT = 3'b010,
    ST_FINISH  = 3'b110
  } seq_state_e;
endpackage

// file: verification/sar_adc_sequencer_accumulator_checker.sv
// Checker with assertions on the converter sequencer ports, bound to the top module.
`timescale 1ns/1ns
module sar_seq_checker
  import sar_seq_pkg::*;
(
  input wire logic                          clock,
  input wire logic                          rst,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [sar_seq_pkg::ADDR_W-1:0] paddr,
  input wire logic [sar_seq_pkg::DATA_W-1:0] prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          standby_sleep,
  input wire logic                          sample_hold_track,
  input wire logic                          converter_powered,
  input wire logic                          compare_strobe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Bus answer timing: one wait state, a single-cycle ready and errors only with ready.
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready missing after access");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside an answer");
  property p_err_hole; pready && paddr == 8'h1C |-> pslverr; endproperty
  a_err_hole: assert property (p_err_hole) else $error("unmapped access not refused");

  // Result bytes are byte wide, so the upper read bits must stay zero.
  property p_hi_byte; pready && !pwrite && paddr == ADDR_RESULT_HI |-> prdata[31:8] == 24'h0;
  endproperty
  a_hi_byte: assert property (p_hi_byte) else $error("high result byte too wide");
  property p_lo_byte; pready && !pwrite && paddr == ADDR_RESULT_LO |-> prdata[31:8] == 24'h0;
  endproperty
  a_lo_byte: assert property (p_lo_byte) else $error("low result byte too wide");

  // Sampling never overlaps a bit decision and never runs in standby.
  property p_standby; standby_sleep && $past(standby_sleep) |-> !sample_hold_track; endproperty
  a_standby: assert property (p_standby) else $error("tracking during standby");
  property p_strobe_hold; compare_strobe |-> !sample_hold_track; endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("decision while tracking");
  property p_strobe_power; compare_strobe |-> converter_powered; endproperty
  a_strobe_power: assert property (p_strobe_power) else $error("decision while off");
endmodule

bind sar_adc_sequencer_accumulator sar_seq_checker sar_seq_checker_i
(
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .standby_sleep(standby_sleep), .sample_hold_track(sample_hold_track),
  .converter_powered(converter_powered), .compare_strobe(compare_strobe)
);

// file: verification/mux_sample_hold_model.sv
// Behavioural analog input and sample capacitor answering the bit decisions MSB first.
`timescale 1ns/1ns
module mux_sample_hold_model
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sample_hold_track,
  input  wire logic       compare_strobe,
  input  wire logic [9:0] input_code,
  output logic            comparator_bit
);
  logic [9:0] held_reg;
  logic [3:0] index_reg;
  logic       decision;

  // The capacitor follows the input only while tracking; a conversion sees the held value.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      held_reg  <= 10'h000;
      index_reg <= 4'h0;
    end
    else if (sample_hold_track)
    begin
      held_reg  <= input_code;
      index_reg <= 4'h0;
    end
    else if (compare_strobe)
      index_reg <= index_reg + 4'h1;
  end

  // Outside a strobe the output is inverted so a stale decision is never mistaken for a fresh one.
  assign decision       = (index_reg < 4'hA) ? held_reg[4'h9 - index_reg] : 1'b0;
  assign comparator_bit = compare_strobe ? decision : ~decision;
endmodule

// file: verification/sar_adc_sequencer_accumulator_tb_top.sv
// Self-checking bench for the converter sequencer driven over its APB registers.
`timescale 1ns/1ns
module sar_adc_sequencer_accumulator_tb_top;
  import sar_seq_pkg::*;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, err, track, powered, cmp, strobe, cclk;
  logic        t0 = 0, t2 = 0, t2l = 0, t2e = 0, t3 = 0, t3l = 0, t3e = 0;
  logic        ext = 0, tick = 0, dsync = 0, stby = 0;
  logic [2:0]  dcnt = 0;
  logic [9:0]  code = 0;
  int          mismatches = 0, samples_checked = 0;

  always #20 clock = ~clock;
  // Oscillator enable every other cycle and a dc-dc clock eight cycles long.
  always @(posedge clock)
  begin
    tick <= ~tick;
    dcnt <= dcnt + 3'h1;
  end

  sar_adc_sequencer_accumulator sar_adc_sequencer_accumulator_i
  (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_overflow(t0), .timer2_overflow(t2), .timer2_low_overflow(t2l),
    .timer2_eight_bit(t2e), .timer3_overflow(t3), .timer3_low_overflow(t3l),
    .timer3_eight_bit(t3e), .external_start_input(ext), .low_power_osc_tick(tick),
    .dcdc_clock_pin(dcnt[2]), .dcdc_sync_pin(dsync), .standby_sleep(stby),
    .comparator_bit(cmp), .sample_hold_track(track), .converter_powered(powered),
    .conversion_clock(cclk), .compare_strobe(strobe)
  );
  mux_sample_hold_model mux_sample_hold_model_i
  (
    .clock(clock), .rst(rst), .sample_hold_track(track), .compare_strobe(strobe),
    .input_code(code), .comparator_bit(cmp)
  );

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clock);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // Polls the done flag; a limit guards against a sequence that never ends.
  task automatic wait_done();
    int n;
    for (n = 0; n < 1500; n++)
    begin
      apb(1'b0, ADDR_CONTROL, 32'h0);
      if (q[CTL_DONE_BIT] === 1'b1)
        break;
    end
    if (n >= 1500)
    begin
      mismatches++;
      finish_test();
    end
  endtask

  task automatic fire(input int s);
    @(posedge clock);
    case (s)
      0: t0 <= 1'b1;
      1: t2 <= 1'b1;
      2: t3 <= 1'b1;
      3: ext <= 1'b1;
      4: t2l <= 1'b1;
      default: t3l <= 1'b1;
    endcase
    @(posedge clock);
    {t0, t2, t3, t2l, t3l} <= 5'h00;
  endtask

  task automatic t_map();
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_ACCUM_CFG, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(ADDR_RESULT_HI, 32'hFF);
    rd(ADDR_RESULT_HI, 32'h0);
  endtask

  task automatic t_single();
    code <= 10'h2A5;
    wr(ADDR_CONTROL, 32'h80);
    wr(ADDR_CONTROL, 32'h90);
    rd(ADDR_CONTROL, 32'h90);
    wait_done();
    rd(ADDR_RESULT_HI, 32'h02);
    rd(ADDR_RESULT_LO, 32'hA5);
    wr(ADDR_ACCUM_CFG, 32'h20);
    wr(ADDR_CONTROL, 32'h90);
    wait_done();
    rd(ADDR_RESULT_HI, 32'hA9);
    rd(ADDR_RESULT_LO, 32'h40);
  endtask

  // Four starts at divider 3, each of the first three followed by an extra start landing in the conversion phase.
  task automatic t_repeat();
    int   n;
    logic c;
    code <= 10'h3FF;
    wr(ADDR_CONFIG, 32'h18);
    // Divider 3 ticks once every four clocks, so any 32 edges hold eight toggles.
    n = 0;
    repeat (32)
    begin
      c = cclk;
      @(posedge clock);
      n += int'(cclk != c);
    end
    check(32'(n), 32'h8);
    wr(ADDR_ACCUM_CFG, 32'h09);
    repeat (3)
    begin
      wr(ADDR_CONTROL, 32'h90);
      wr(ADDR_CONTROL, 32'h90);
      rd(ADDR_CONTROL, 32'h90);
      for (n = 0; n < 50 && q[CTL_BUSY_BIT] === 1'b1; n++)
        apb(1'b0, ADDR_CONTROL, 32'h0);
      if (n >= 50)
      begin
        mismatches++;
        finish_test();
      end
    end
    rd(ADDR_CONTROL, 32'h80);
    rd(ADDR_RESULT_HI, 32'hA9);
    wr(ADDR_CONTROL, 32'h90);
    repeat (28) @(posedge clock);
    rd(ADDR_CONTROL, 32'h90);
    wait_done();
    rd(ADDR_RESULT_HI, 32'h07);
    rd(ADDR_RESULT_LO, 32'hFE);
    wr(ADDR_CONFIG, 32'h0);
  endtask

  task automatic t_burst();
    wr(ADDR_ACCUM_CFG, 32'h05);
    wr(ADDR_CONTROL, 32'h40);
    wr(ADDR_CONTROL, 32'h50);
    wait_done();
    rd(ADDR_RESULT_HI, 32'hFF);
    rd(ADDR_RESULT_LO, 32'hC0);
    check({31'h0, powered}, 32'h0);
    wr(ADDR_ACCUM_CFG, 32'h0);
  endtask

  task automatic t_sources();
    logic [2:0] tab [6] = '{SRC_TIMER0, SRC_TIMER2, SRC_TIMER3, SRC_EXTERNAL, SRC_TIMER2,
                            SRC_TIMER3};
    for (int i = 0; i < 6; i++)
    begin
      code <= 10'h100 + 10'(i);
      t2e <= (i == 4);
      t3e <= (i == 5);
      wr(ADDR_CONTROL, 32'h80 | 32'(tab[i]));
      fire(i);
      wait_done();
      rd(ADDR_RESULT_LO, 32'(i));
      ext <= 1'b0;
    end
  endtask

  task automatic t_modes();
    code <= 10'h2A7;
    wr(ADDR_CONFIG, 32'h04);
    wr(ADDR_CONTROL, 32'h90);
    wait_done();
    rd(ADDR_RESULT_LO, 32'hA4);
    wr(ADDR_CONFIG, 32'h0);
    wr(ADDR_DCDC_CFG, 32'h03);
    wr(ADDR_CONTROL, 32'h90);
    repeat (40) @(posedge clock);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check(q, 32'h80);
    dsync <= 1'b1;
    repeat (3) @(posedge clock);
    dsync <= 1'b0;
    wait_done();
    rd(ADDR_RESULT_LO, 32'hA7);
    wr(ADDR_DCDC_CFG, 32'h0);
  endtask

  task automatic t_track();
    stby <= 1'b1;
    repeat (2) @(posedge clock);
    check({31'h0, track}, 32'h0);
    stby <= 1'b0;
    wr(ADDR_CONTROL, 32'h80);
    check({31'h0, track}, 32'h1);
    wr(ADDR_CONTROL, 32'h8C);
    check({31'h0, track}, 32'h1);
    fire(3);
    wait_done();
    rd(ADDR_RESULT_LO, 32'hA7);
    ext <= 1'b0;
    wr(ADDR_CONFIG, 32'hF8);
    wr(ADDR_CONTROL, 32'h88);
    check({31'h0, track}, 32'h0);
    wr(ADDR_CONTROL, 32'h98);
    repeat (2) @(posedge clock);
    check({31'h0, track}, 32'h1);
    wait_done();
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_map();
    t_single();
    t_repeat();
    t_burst();
    t_sources();
    t_modes();
    t_track();
    finish_test();
  end
endmodule
